// >>> src/event_flags_cfg.svh
`ifndef EVENT_FLAGS_CFG_SVH
`define EVENT_FLAGS_CFG_SVH

// Register index (offset) of each flag register
`define FLAGS_A_OFFSET 8'h00
`define FLAGS_B_OFFSET 8'h01

// Reset value of both flag registers
`define FLAGS_RESET 8'h00

// Reset value of the power-good history bit
`define PGOOD_HIST_RESET 1'b0

// Bit positions in flag register A
`define BIT_LDO_UV 2
`define BIT_IN_OC 1
`define BIT_EXT_REG 0

// Bit positions in flag register B
`define BIT_IN_OV 7
`define BIT_SYS_UVLO 6
`define BIT_SYS_RST 5
`define BIT_SYS_BO 4
`define BIT_THERM 3
`define BIT_SW_OFF 2
`define BIT_BUS_WD 1
`define BIT_BIAS_RDY 0

`endif

// >>> src/event_flags_pkg.sv
package event_flags_pkg;
  // One register byte
  typedef logic [7:0] byte_t;
endpackage

// >>> src/global_event_flag_registers.sv
`timescale 1ns/1ps
`include "event_flags_cfg.svh"
module global_event_flag_registers (
  input wire logic SYS_CLK, // 250 MHz clock
  input wire logic RSTN, // Sync reset, supply reset level
  input wire logic CLK_EN, // Freezes all state when low
  input wire logic RD_STB, // One-cycle register read strobe
  input wire logic WR_STB, // One-cycle register write strobe
  input wire logic [7:0] REG_ADDR, // Register offset
  input wire logic [7:0] WR_DATA, // Write data, ignored here
  output logic [7:0] RD_DATA, // Read data, valid cycle after RD_STB
  output logic RD_VALID, // Read data valid pulse
  input wire logic LDO_UV_EVT, // LDO enabled into undervoltage pulse
  input wire logic IN_OC_EVT, // Input overcurrent pulse
  input wire logic EXT_REGULATOR_POWER_GOOD_IN, // Ext power-good level
  input wire logic EXT_REGULATOR_MONITOR_MASK, // 1 = not monitored
  input wire logic EXT_REGULATOR_LISTEN_ENABLE, // Controller listens
  input wire logic EXT_ENABLE_A_SEQUENCER_ASSIGN, // Enable A assigned
  input wire logic EXT_ENABLE_B_SEQUENCER_ASSIGN, // Enable B assigned
  input wire logic IN_OV_EVT, // Inrush input over lockout pulse
  input wire logic SYS_UVLO_EVT, // Supply under UVLO pulse
  input wire logic SYS_RST_EVT, // Supply under reset level pulse
  input wire logic SYS_BO_EVT, // Supply under brownout pulse
  input wire logic THERM_OVLD_EVT, // Thermal overload pulse
  input wire logic POWEROFF_WITH_RESET_REQUEST, // Written-one pulse
  input wire logic POWEROFF_NO_RESET_REQUEST, // Written-one pulse
  input wire logic BUS_WD_EVT, // Bus watchdog expiry pulse
  input wire logic BIAS_RDY_EVT, // Bias ready pulse
  output logic [7:0] GLOBAL_EVENT_FLAGS_A, // Live view of flags A
  output logic [7:0] GLOBAL_EVENT_FLAGS_B // Live view of flags B
);

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  event_flags_pkg::byte_t global_event_flags_a_r;
  event_flags_pkg::byte_t global_event_flags_b_r;
  event_flags_pkg::byte_t set_a_nxt;
  event_flags_pkg::byte_t set_b_nxt;
  event_flags_pkg::byte_t global_event_flags_a_nxt;
  event_flags_pkg::byte_t global_event_flags_b_nxt;
  logic pgood_prev_r;
  logic pgood_fall;
  logic ext_watch;
  logic rd_a;
  logic rd_b;

  // Edge is taken on the previous sample so a steady level never flags
  assign pgood_fall = pgood_prev_r & ~EXT_REGULATOR_POWER_GOOD_IN;
  assign ext_watch = ~EXT_REGULATOR_MONITOR_MASK
    & EXT_REGULATOR_LISTEN_ENABLE
    & (EXT_ENABLE_A_SEQUENCER_ASSIGN | EXT_ENABLE_B_SEQUENCER_ASSIGN);

  // Writes never reach the flags
  assign rd_a = RD_STB & (REG_ADDR == `FLAGS_A_OFFSET);
  assign rd_b = RD_STB & (REG_ADDR == `FLAGS_B_OFFSET);

  // Set vectors, one bit per event source except the two power-off requests, which share one
  always_comb begin
    set_a_nxt = `FLAGS_RESET;
    set_b_nxt = `FLAGS_RESET;
    set_a_nxt[`BIT_LDO_UV] = LDO_UV_EVT;
    set_a_nxt[`BIT_IN_OC] = IN_OC_EVT;
    set_a_nxt[`BIT_EXT_REG] = pgood_fall & ext_watch;
    set_b_nxt[`BIT_IN_OV] = IN_OV_EVT;
    set_b_nxt[`BIT_SYS_UVLO] = SYS_UVLO_EVT;
    set_b_nxt[`BIT_SYS_RST] = SYS_RST_EVT;
    set_b_nxt[`BIT_SYS_BO] = SYS_BO_EVT;
    set_b_nxt[`BIT_THERM] = THERM_OVLD_EVT;
    set_b_nxt[`BIT_SW_OFF] = POWEROFF_WITH_RESET_REQUEST
      | POWEROFF_NO_RESET_REQUEST;
    set_b_nxt[`BIT_BUS_WD] = BUS_WD_EVT;
    set_b_nxt[`BIT_BIAS_RDY] = BIAS_RDY_EVT;
  end

  // Set wins over the read clear so no event is lost
  always_comb begin
    global_event_flags_a_nxt = (rd_a ? `FLAGS_RESET
      : global_event_flags_a_r) | set_a_nxt;
    global_event_flags_b_nxt = (rd_b ? `FLAGS_RESET
      : global_event_flags_b_r) | set_b_nxt;
  end

  // ----------------------------------------------------------------
  // Flag state
  // ----------------------------------------------------------------
  // Power-good history; reset low so an input held low out of reset
  // never counts as a falling edge, only a seen high arms the detector
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      pgood_prev_r <= `PGOOD_HIST_RESET;
    end else if (CLK_EN) begin
      pgood_prev_r <= EXT_REGULATOR_POWER_GOOD_IN;
    end
  end

  // Sticky flags, cleared only by reset or by reading
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      global_event_flags_a_r <= `FLAGS_RESET;
      global_event_flags_b_r <= `FLAGS_RESET;
    end else if (CLK_EN) begin
      global_event_flags_a_r <= global_event_flags_a_nxt;
      global_event_flags_b_r <= global_event_flags_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Return the pre-clear value; unmapped offsets read zero
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      RD_DATA <= `FLAGS_RESET;
      RD_VALID <= 1'b0;
    end else if (CLK_EN) begin
      RD_VALID <= RD_STB;
      if (rd_a) begin
        RD_DATA <= global_event_flags_a_r;
      end else if (rd_b) begin
        RD_DATA <= global_event_flags_b_r;
      end else begin
        RD_DATA <= `FLAGS_RESET;
      end
    end
  end

  // Registered copies of the flags for the interrupt logic outside
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      GLOBAL_EVENT_FLAGS_A <= `FLAGS_RESET;
      GLOBAL_EVENT_FLAGS_B <= `FLAGS_RESET;
    end else if (CLK_EN) begin
      GLOBAL_EVENT_FLAGS_A <= global_event_flags_a_nxt;
      GLOBAL_EVENT_FLAGS_B <= global_event_flags_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ldo_uv_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN && LDO_UV_EVT |=> global_event_flags_a_r[`BIT_LDO_UV])
    else $error("LDO undervoltage flag not set");
  a_in_oc_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN && IN_OC_EVT |=> global_event_flags_a_r[`BIT_IN_OC])
    else $error("Input overcurrent flag not set");
  a_ext_reg_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN && $past(CLK_EN) && $past(RSTN) && ext_watch
    && $fell(EXT_REGULATOR_POWER_GOOD_IN)
    |=> global_event_flags_a_r[`BIT_EXT_REG])
    else $error("External regulator flag not set");
  a_ext_reg_idle: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN)
    CLK_EN && EXT_REGULATOR_POWER_GOOD_IN && !rd_a
    |=> global_event_flags_a_r[`BIT_EXT_REG]
      == $past(global_event_flags_a_r[`BIT_EXT_REG]))
    else $error("External regulator flag changed on high input");
  a_ext_reg_quiet: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN)
    CLK_EN && EXT_REGULATOR_MONITOR_MASK && !rd_a
    |=> global_event_flags_a_r[`BIT_EXT_REG]
      == $past(global_event_flags_a_r[`BIT_EXT_REG]))
    else $error("Masked external regulator flag changed");
  a_b_flags_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN |=> (global_event_flags_b_r & $past(set_b_nxt))
      == $past(set_b_nxt))
    else $error("Flag B event not latched");
  a_sw_off_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN && POWEROFF_NO_RESET_REQUEST
    |=> global_event_flags_b_r[`BIT_SW_OFF])
    else $error("Software power-off flag not set");
  a_sw_off_rst: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN && POWEROFF_WITH_RESET_REQUEST
    |=> global_event_flags_b_r[`BIT_SW_OFF])
    else $error("Software power-off with reset flag not set");
  a_read_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN && rd_b && set_b_nxt == `FLAGS_RESET
    |=> global_event_flags_b_r == `FLAGS_RESET
      && RD_VALID && RD_DATA == $past(global_event_flags_b_r))
    else $error("Read did not return and clear flags B");
  a_read_clear_a: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN)
    CLK_EN && rd_a && set_a_nxt == `FLAGS_RESET
    |=> global_event_flags_a_r == `FLAGS_RESET
      && RD_VALID && RD_DATA == $past(global_event_flags_a_r))
    else $error("Read did not return and clear flags A");
  a_read_valid: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN |=> RD_VALID == $past(RD_STB))
    else $error("Read valid does not follow the read strobe");
  a_write_ignored: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN)
    CLK_EN && WR_STB && !RD_STB && set_a_nxt == `FLAGS_RESET
    |=> global_event_flags_a_r == $past(global_event_flags_a_r))
    else $error("Write changed flags A");
  a_set_wins: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN && rd_a && IN_OC_EVT |=> global_event_flags_a_r[`BIT_IN_OC])
    else $error("Event lost on clearing read");

  // Main scenarios worth seeing in coverage
  c_read_a: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
    rd_a && global_event_flags_a_r != `FLAGS_RESET);
  c_read_b: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
    rd_b && global_event_flags_b_r != `FLAGS_RESET);
  c_ext_fall: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
    set_a_nxt[`BIT_EXT_REG]);
  c_race: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
    rd_b && set_b_nxt != `FLAGS_RESET);
  c_both_poweroff: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
    POWEROFF_WITH_RESET_REQUEST && POWEROFF_NO_RESET_REQUEST);

endmodule // global_event_flag_registers

// >>> tb/flag_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side: issues register reads/writes
// ----------------------------------------
module flag_host (
  input wire logic clk, // Bench clock
  input wire logic do_rd, // Ask for one read
  input wire logic do_wr, // Ask for one write
  input wire logic [7:0] addr, // Wanted offset
  input wire logic [2:0] wdata, // Low write bits
  output logic rd_stb, // Read strobe to device
  output logic wr_stb, // Write strobe to device
  output logic [7:0] reg_addr, // Offset to device
  output logic [7:0] wr_data // Write byte to device
);
  // Registered so every request leaves just after an edge
  always_ff @(posedge clk) begin
    rd_stb <= do_rd;
    wr_stb <= do_wr;
    reg_addr <= addr;
    wr_data <= {5'h00, wdata};
  end
endmodule // flag_host

// >>> tb/global_event_flag_registers_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module global_event_flag_registers_test;
  logic clk = 0, rstn = 0, clk_en = 1, do_rd = 0, do_wr = 0, ev = 0, pg_q = 1;
  logic rd_stb, wr_stb, rd_valid;
  logic [7:0] addr = 8'h00, reg_addr, wr_data, rd_data, fa, fb;
  logic [2:0] wdata = 3'h0;
  logic [10:0] evt = 11'h000; // ldo,oc,ov,uvlo,rst,bo,th,off_r,off_n,wd,bias
  logic [4:0] lvl = 5'h01; // pgood,mask,listen,assign_a,assign_b
  event_flags_pkg::byte_t ea = 8'h00, eb = 8'h00, ed = 8'h00;
  int n_mismatch = 0, tests_run = 0;
  wire logic fall = pg_q & ~lvl[4] & ~lvl[3] & lvl[2] & (lvl[1] | lvl[0]);
  always #2 clk = ~clk;
  flag_host i_host (.clk(clk), .do_rd(do_rd), .do_wr(do_wr), .addr(addr),
    .wdata(wdata), .rd_stb(rd_stb), .wr_stb(wr_stb), .reg_addr(reg_addr),
    .wr_data(wr_data));
  global_event_flag_registers i_dut (.SYS_CLK(clk), .RSTN(rstn),
    .CLK_EN(clk_en), .RD_STB(rd_stb), .WR_STB(wr_stb), .REG_ADDR(reg_addr),
    .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .LDO_UV_EVT(evt[10]), .IN_OC_EVT(evt[9]),
    .EXT_REGULATOR_POWER_GOOD_IN(lvl[4]), .EXT_REGULATOR_MONITOR_MASK(lvl[3]),
    .EXT_REGULATOR_LISTEN_ENABLE(lvl[2]),
    .EXT_ENABLE_A_SEQUENCER_ASSIGN(lvl[1]),
    .EXT_ENABLE_B_SEQUENCER_ASSIGN(lvl[0]), .IN_OV_EVT(evt[8]),
    .SYS_UVLO_EVT(evt[7]), .SYS_RST_EVT(evt[6]), .SYS_BO_EVT(evt[5]),
    .THERM_OVLD_EVT(evt[4]), .POWEROFF_WITH_RESET_REQUEST(evt[3]),
    .POWEROFF_NO_RESET_REQUEST(evt[2]), .BUS_WD_EVT(evt[1]),
    .BIAS_RDY_EVT(evt[0]), .GLOBAL_EVENT_FLAGS_A(fa),
    .GLOBAL_EVENT_FLAGS_B(fb));
  // Set wins over the read clear, so no event is lost
  function automatic event_flags_pkg::byte_t upd(
    input event_flags_pkg::byte_t cur, input event_flags_pkg::byte_t set,
    input logic clr);
    return (clr ? 8'h00 : cur) | set;
  endfunction
  // ----------------------------------------
  // Reference: same cycle model as the flags
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      {ea, eb, ed, ev, pg_q} <= {24'h00_0000, 2'b00};
    end else if (clk_en) begin
      ev <= rd_stb;
      ed <= !rd_stb ? 8'h00 : reg_addr == 8'h00 ? ea :
        reg_addr == 8'h01 ? eb : 8'h00;
      ea <= upd(ea, {5'h00, evt[10:9], fall}, rd_stb && reg_addr == 8'h00);
      eb <= upd(eb, {evt[8:4], evt[3] | evt[2], evt[1:0]},
        rd_stb && reg_addr == 8'h01);
      pg_q <= lvl[4];
    end
  end
  // Outputs settle by the falling edge
  always @(negedge clk) begin
    if (rstn) begin
      `CHK("flags_a", ea, fa)
      `CHK("flags_b", eb, fb)
      `CHK("rd_valid", ev, rd_valid)
      `CHK("rd_data", ed, rd_data)
    end
  end
  task automatic step(input logic [10:0] e, input logic [4:0] l,
    input logic r, input logic [7:0] a, input logic en);
    @(posedge clk);
    evt <= e;
    lvl <= l;
    do_rd <= r;
    addr <= a;
    clk_en <= en;
    do_wr <= 1'($urandom);
    wdata <= 3'($urandom);
  endtask
  // Events on about one step in dens (every step when dens is 1), mixed with reads on random steps, or on every step when busy
  task automatic burst(input string nm, input int n, input int dens,
    input logic busy);
    repeat (n) begin
      step(($urandom % dens == 0) ? 11'($urandom) : 11'h000, 5'($urandom),
        busy | 1'($urandom), 8'($urandom_range(2)), busy | ($urandom % 8 != 0));
    end
    $display("test %s done, mismatches %0d", nm, n_mismatch);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(69));
    repeat (12) @(posedge clk);
    rstn <= 1;
    burst("random", 3000, 6, 1'b0);
    burst("back_to_back", 500, 1, 1'b1);
    // Power-good fall under every gating combination
    for (int c = 0; c < 16; c++) begin
      step(11'h000, {1'b1, 4'(c)}, 1'b0, 8'h00, 1'b1);
      step(11'h000, {1'b0, 4'(c)}, 1'b1, 8'h00, 1'b1);
      step(11'h000, {1'b0, 4'(c)}, 1'b0, 8'h00, 1'b1);
    end
    $display("test gating done, mismatches %0d", n_mismatch);
    step(11'h000, 5'h10, 1'b0, 8'h00, 1'b1);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    burst("after_reset", 500, 3, 1'b0);
    summarize();
  end
endmodule // global_event_flag_registers_test
